// [tb_touch_baseline_detect.sv]
// Self-checking testbench of the touch baseline detector
module tb_touch_baseline_detect;
  timeunit 1ns;
  timeprecision 1ps;
  import tbd_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, setup = 1'b0, tick, cstart, csel, svld;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, blu = 8'h03;
  logic [15:0] raw, ft = 16'hffff, nt = 16'h0a0a;
  logic [31:0] raw_set = {16'd1000, 16'd1000}, bl;
  logic [1:0] act;
  int num_errors = 0, compares = 0;
  always #5 clk = ~clk;
  tbd_touch_baseline_detect dut (.CORE_CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SETUP_MODE_I(setup), .SCAN_TICK_O(tick),
    .CONV_START_O(cstart), .CONV_SENSOR_O(csel), .SAMPLE_VALID_I(svld), .RAW_COUNT_I(raw),
    .FINGER_TH_I(ft), .NOISE_TH_I(nt), .BL_UPDATE_TH_I(blu), .SENSOR_ACTIVE_O(act), .BASELINE_O(bl));
  tbd_frontend_model #(.DLY(2)) u_fe (.clk_i(clk), .rst_i(rst), .conv_start_i(cstart),
    .conv_sensor_i(csel), .raw_set_i(raw_set), .sample_valid_o(svld), .raw_count_o(raw));
  //============================================================
  // Shared tasks
  task automatic finish_test;
    $display("Compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    setup = s;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    addr = a;
    #1;
  endtask
  // Wait for n taken samples of sensor s, then let the results land
  task automatic smp(input logic s, input int n);
    int k;
    k = 0;
    for (int i = 0; i < 4000 && k < n; i++)
    begin
      // Mid-cycle look: the handshake stands there, away from the launching edge
      @(negedge clk);
      if (cstart === 1'b1 && svld === 1'b1 && csel === s)
        k++;
    end
    if (k < n)
    begin
      num_errors++;
      finish_test;
    end
    @(posedge clk);
    #1;
  endtask
  //============================================================
  // Scenarios
  task automatic t_regs;
    logic [7:0] rv [6] = '{TBD_RST_SETTLE, TBD_RST_CLKAR, TBD_RST_HYST, TBD_RST_DEBOUNCE, TBD_RST_NEGNOISE, TBD_RST_LOWRST};
    for (int i = 0; i < 6; i++)
    begin
      rd(TBD_ADDR_SETTLE + 8'(i));
      chk("reset value", rdata, rv[i]);
    end
    rd(8'h56);
    chk("unmapped", rdata, 8'h00);
    wr_reg(TBD_ADDR_SETTLE, 8'h33, 1'b0);
    chk("settle normal", rdata, 8'ha0);
    wr_reg(TBD_ADDR_SETTLE, 8'h02, 1'b1);
    chk("settle setup", rdata, 8'h02);
    ft = 16'h1414;
    wr_reg(TBD_ADDR_CLKAR, 8'hff, 1'b1);
    chk("clock mask", rdata, TBD_CLKAR_MASK);
    wr_reg(TBD_ADDR_CLKAR, 8'h00, 1'b0);
    chk("clock normal", rdata, TBD_CLKAR_MASK);
  endtask
  task automatic t_clk;
    int n;
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(TBD_ADDR_CLKAR, 8'(s << 5), 1'b1);
      repeat (8) @(posedge clk);
      n = 0;
      repeat (64)
      begin
        @(negedge clk);
        if (tick === 1'b1)
          n++;
      end
      chk("ticks", 16'(n), 16'(64 >> s));
    end
  endtask
  task automatic t_detect;
    wr_reg(TBD_ADDR_CLKAR, 8'h08, 1'b1);
    smp(1'b0, 2);
    chk("auto bl0", bl[15:0], 16'd1000);
    chk("auto bl1", bl[31:16], 16'd1000);
    wr_reg(TBD_ADDR_CLKAR, 8'h00, 1'b1);
    wr_reg(TBD_ADDR_HYST, 8'h05, 1'b0);
    wr_reg(TBD_ADDR_DEBOUNCE, 8'h03, 1'b0);
    raw_set[15:0] = 16'd1025;
    smp(1'b0, 4);
    chk("at ft+hys", 16'(act[0]), 16'h0000);
    chk("big diff bl", bl[15:0], 16'd1000);
    raw_set[15:0] = 16'd1026;
    smp(1'b0, 2);
    chk("debounce 2", 16'(act[0]), 16'h0000);
    smp(1'b0, 1);
    chk("debounce 3", 16'(act[0]), 16'h0001);
    raw_set[15:0] = 16'd1015;
    smp(1'b0, 2);
    chk("at ft-hys", 16'(act[0]), 16'h0001);
    raw_set[15:0] = 16'd1014;
    smp(1'b0, 1);
    chk("below ft-hys", 16'(act[0]), 16'h0000);
    chk("other sensor", 16'(act[1]), 16'h0000);
  endtask
  task automatic t_base;
    raw_set[31:16] = 16'd1003;
    smp(1'b1, 2);
    chk("bucket bl1", bl[31:16], 16'd1001);
    wr_reg(TBD_ADDR_LOWRST, 8'h03, 1'b0);
    raw_set[15:0] = 16'd980;
    smp(1'b0, 2);
    chk("low held", bl[15:0], 16'd1000);
    smp(1'b0, 1);
    chk("low reload", bl[15:0], 16'd980);
    // With auto reset on, even a dip beyond the negative noise level is followed at once
    wr_reg(TBD_ADDR_CLKAR, 8'h08, 1'b1);
    raw_set[15:0] = 16'd950;
    smp(1'b0, 1);
    chk("auto deep dip", bl[15:0], 16'd950);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs;
    t_clk;
    t_detect;
    t_base;
    finish_test;
  end
endmodule

// [tbd_frontend_model.sv]
// Sensor front end model answering conversion requests with raw counts
module tbd_frontend_model #(
  parameter int DLY = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Conversion handshake
  input wire logic conv_start_i,
  input wire logic conv_sensor_i,
  input wire logic [31:0] raw_set_i,
  output logic sample_valid_o,
  output logic [15:0] raw_count_o
);
  logic [3:0] cnt;
  logic [15:0] held;
  // Off the strobe the bus shows the inverse of the last count, never a stale copy
  assign raw_count_o = sample_valid_o ? raw_set_i[conv_sensor_i*16 +: 16] : ~held;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt <= 4'h0;
      held <= 16'h0000;
      sample_valid_o <= 1'b0;
    end
    else
    begin
      sample_valid_o <= 1'b0;
      if (sample_valid_o)
      begin
        cnt <= 4'h0;
        held <= raw_count_o;
      end
      else if (conv_start_i && cnt == 4'(DLY))
        sample_valid_o <= 1'b1;
      else if (conv_start_i)
        cnt <= cnt + 4'h1;
    end
endmodule

// [tbd_monitor.sv]
// Checker on the top ports of the touch baseline detector
module tbd_monitor #(
  parameter int NUM_SENSORS = 2,
  parameter int CW = 16
) (
  // Clock, reset, register port
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic SETUP_MODE_I,
  // Scan and results
  input wire logic SCAN_TICK_O,
  input wire logic CONV_START_O,
  input wire logic [$clog2(NUM_SENSORS)-1:0] CONV_SENSOR_O,
  input wire logic SAMPLE_VALID_I,
  input wire logic [NUM_SENSORS-1:0] SENSOR_ACTIVE_O,
  input wire logic [NUM_SENSORS*CW-1:0] BASELINE_O
);
  logic [1:0] sel;
  logic [4:0] quiet;
  logic [2:0] gap;
  logic tk;
  assign tk = CONV_START_O && SAMPLE_VALID_I;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  //============================================================
  // Helpers: tick spacing is judged only once a new divider has settled
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
    if (RST_I)
    begin
      sel <= 2'h0;
      quiet <= 5'h00;
    end
    else if (REG_WR_I && SETUP_MODE_I && REG_ADDR_I == 8'h51)
    begin
      sel <= REG_WDATA_I[6:5];
      quiet <= 5'h00;
    end
    else if (quiet != 5'h1f)
      quiet <= quiet + 5'h01;
  always_ff @(posedge CORE_CLK_I or posedge RST_I)
    if (RST_I)
      gap <= 3'h0;
    else
      gap <= SCAN_TICK_O ? 3'h0 : gap + 3'h1;
  //============================================================
  // Assertions
  setup_gate_a: assert property (
    (REG_WR_I && !SETUP_MODE_I && REG_ADDR_I inside {8'h50, 8'h51}) ##1 $stable(REG_ADDR_I) |-> $stable(REG_RDATA_O))
    else $error("normal mode write took effect");
  clk_mask_a: assert property (
    (REG_WR_I && SETUP_MODE_I && REG_ADDR_I == 8'h51) ##1 (REG_ADDR_I == 8'h51) |-> REG_RDATA_O == ($past(REG_WDATA_I) & 8'h68))
    else $error("clock register write wrong");
  tick_gap_a: assert property (SCAN_TICK_O && quiet > 5'h10 |-> gap == 3'((4'h1 << sel) - 4'h1))
    else $error("scan tick spacing wrong");
  conv_hold_a: assert property (CONV_START_O && !SAMPLE_VALID_I |=> CONV_START_O)
    else $error("conversion dropped without sample");
  conv_settle_a: assert property (tk |=> !CONV_START_O [*2])
    else $error("settle phase too short");
  sensor_rr_a: assert property (tk |=> CONV_SENSOR_O == $past(CONV_SENSOR_O) + 1'b1)
    else $error("sensor order wrong");
  active_cause_a: assert property ($changed(SENSOR_ACTIVE_O) |-> $past(tk))
    else $error("active changed without sample");
  baseline_cause_a: assert property ($changed(BASELINE_O) |-> $past(tk))
    else $error("baseline changed without sample");
  cover property (tk);
  cover property ($rose(SENSOR_ACTIVE_O[0]));
  cover property (REG_WR_I && !SETUP_MODE_I && REG_ADDR_I == 8'h50);
endmodule
bind tbd_touch_baseline_detect tbd_monitor #(.NUM_SENSORS(NUM_SENSORS), .CW(CW)) u_mon (
  .CORE_CLK_I, .RST_I, .REG_WR_I, .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O, .SETUP_MODE_I,
  .SCAN_TICK_O, .CONV_START_O, .CONV_SENSOR_O, .SAMPLE_VALID_I, .SENSOR_ACTIVE_O, .BASELINE_O);

// [tbd_pkg.sv]
// Package: register map, reset values and field layout of the touch baseline detector
//==============================================================================
// Overview of operation
// [RULE1] Settling value sets the conversion phase length; resets to a0, range 2 to 255.
// [RULE2] Settling and clock/auto-reset writes take effect only in setup mode.
// [RULE3] Host programs settling time before finger threshold and current-source settings.
// [RULE4] Clock select bits 6:5 divide oscillator by 1, 2, 4 or 8.
// [RULE5] Auto-reset set: baseline updates on every sample regardless of difference.
// [RULE6] Auto-reset clear: baseline updates only when difference is below noise threshold.
// [RULE7] Inactive sensor is candidate when difference exceeds threshold plus hysteresis.
// [RULE8] Active sensor turns inactive when difference falls below threshold minus hysteresis.
// [RULE9] Host keeps hysteresis 0 to 255 and below the finger threshold.
// [RULE10] Activation needs debounce-count consecutive samples above threshold plus hysteresis.
// [RULE11] Raw far below baseline by more than negative noise leaves baseline unchanged; here only with auto-reset clear.
// [RULE12] Count such low samples; at the reset count load baseline with raw.
// [RULE13] All tuning settings are shared by every sensor; here finger and noise thresholds come per sensor.
// [RULE14] Samples above baseline beyond the noise threshold do not update the baseline.
// [RULE15] Small positive differences fill a bucket; full bucket bumps baseline, then clears.
// [RULE16] Difference is raw minus baseline, computed once per sample before detection.
package tbd_pkg;
  //============================================================================
  // Register offsets
  localparam logic [7:0] TBD_ADDR_SETTLE = 8'h50;
  localparam logic [7:0] TBD_ADDR_CLKAR = 8'h51;
  localparam logic [7:0] TBD_ADDR_HYST = 8'h52;
  localparam logic [7:0] TBD_ADDR_DEBOUNCE = 8'h53;
  localparam logic [7:0] TBD_ADDR_NEGNOISE = 8'h54;
  localparam logic [7:0] TBD_ADDR_LOWRST = 8'h55;
  //============================================================================
  // Reset values
  localparam logic [7:0] TBD_RST_SETTLE = 8'ha0;
  localparam logic [7:0] TBD_RST_CLKAR = 8'h00;
  localparam logic [7:0] TBD_RST_HYST = 8'h0a;
  localparam logic [7:0] TBD_RST_DEBOUNCE = 8'h0a;
  localparam logic [7:0] TBD_RST_NEGNOISE = 8'h0a;
  localparam logic [7:0] TBD_RST_LOWRST = 8'h0a;
  //============================================================================
  // Fields of the clock/auto-reset register
  localparam int TBD_CLKSEL_LSB = 5;
  localparam int TBD_CLKSEL_MSB = 6;
  localparam int TBD_AUTORST_BIT = 3;
  localparam logic [7:0] TBD_CLKAR_MASK = 8'h68;
  // Settling counts below this are treated as this
  localparam logic [7:0] TBD_SETTLE_MIN = 8'h02;
endpackage

// [tbd_touch_baseline_detect.sv]
// Top: tuning registers, scan clock divider, per-sensor detection and baseline tracking
module tbd_touch_baseline_detect #(
  parameter int NUM_SENSORS = 2,
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic SETUP_MODE_I,
  // Conversion front end
  output logic SCAN_TICK_O,
  output logic CONV_START_O,
  output logic [$clog2(NUM_SENSORS)-1:0] CONV_SENSOR_O,
  input wire logic SAMPLE_VALID_I,
  input wire logic [CW-1:0] RAW_COUNT_I,
  // Thresholds from outside: finger and noise per sensor, baseline update shared
  input wire logic [NUM_SENSORS*8-1:0] FINGER_TH_I,
  input wire logic [NUM_SENSORS*8-1:0] NOISE_TH_I,
  input wire logic [7:0] BL_UPDATE_TH_I,
  // Results
  output logic [NUM_SENSORS-1:0] SENSOR_ACTIVE_O,
  output logic [NUM_SENSORS*CW-1:0] BASELINE_O
);
  import tbd_pkg::*;

  localparam int SW = (NUM_SENSORS > 1) ? $clog2(NUM_SENSORS) : 1;

  typedef enum logic [1:0] {TBD_IDLE, TBD_SETTLE, TBD_WAIT} tbd_state_e;

  //============================================================================
  // Tuning registers (shared by all sensors)
  logic [7:0] settling_time;
  logic [7:0] scan_clock_autoreset;
  logic [7:0] detect_hysteresis;
  logic [7:0] activation_debounce;
  logic [7:0] negative_noise_threshold;
  logic [7:0] low_baseline_reset_count;

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      settling_time <= TBD_RST_SETTLE; // [RULE1]
      scan_clock_autoreset <= TBD_RST_CLKAR;
      detect_hysteresis <= TBD_RST_HYST; // [RULE7]
      activation_debounce <= TBD_RST_DEBOUNCE;
      negative_noise_threshold <= TBD_RST_NEGNOISE;
      low_baseline_reset_count <= TBD_RST_LOWRST;
    end
    else if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        TBD_ADDR_SETTLE: if (SETUP_MODE_I) settling_time <= REG_WDATA_I; // [RULE2]
        TBD_ADDR_CLKAR: if (SETUP_MODE_I) scan_clock_autoreset <= REG_WDATA_I & TBD_CLKAR_MASK; // [RULE2]
        TBD_ADDR_HYST: detect_hysteresis <= REG_WDATA_I;
        TBD_ADDR_DEBOUNCE: activation_debounce <= REG_WDATA_I;
        TBD_ADDR_NEGNOISE: negative_noise_threshold <= REG_WDATA_I;
        TBD_ADDR_LOWRST: low_baseline_reset_count <= REG_WDATA_I;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    unique case (REG_ADDR_I)
      TBD_ADDR_SETTLE: REG_RDATA_O = settling_time;
      TBD_ADDR_CLKAR: REG_RDATA_O = scan_clock_autoreset;
      TBD_ADDR_HYST: REG_RDATA_O = detect_hysteresis;
      TBD_ADDR_DEBOUNCE: REG_RDATA_O = activation_debounce;
      TBD_ADDR_NEGNOISE: REG_RDATA_O = negative_noise_threshold;
      TBD_ADDR_LOWRST: REG_RDATA_O = low_baseline_reset_count;
      default: REG_RDATA_O = 8'h00;
    endcase
  end

  //============================================================================
  // Scan clock divider: a one-cycle tick at oscillator/1, /2, /4 or /8
  logic [2:0] div_cnt;
  logic [2:0] div_mask;
  logic auto_baseline_reset;

  assign auto_baseline_reset = scan_clock_autoreset[TBD_AUTORST_BIT];

  always_comb
  begin
    unique case (scan_clock_autoreset[TBD_CLKSEL_MSB:TBD_CLKSEL_LSB]) // [RULE4]
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      div_cnt <= 3'h0;
    else
      div_cnt <= (div_cnt & div_mask) == div_mask ? 3'h0 : div_cnt + 3'h1;
  end

  assign SCAN_TICK_O = (div_cnt & div_mask) == div_mask; // [RULE4]

  //============================================================================
  // Scan sequencer: settle for settle_target ticks, then await the sample
  tbd_state_e state;
  logic [7:0] settle_delay;
  logic [SW-1:0] cur_sensor;
  logic [7:0] settle_target;

  // Values below the documented floor would collapse the conversion phase
  assign settle_target = (settling_time < TBD_SETTLE_MIN) ? TBD_SETTLE_MIN : settling_time;

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state <= TBD_IDLE;
      settle_delay <= 8'h00;
      cur_sensor <= '0;
    end
    else
    begin
      unique case (state)
        TBD_IDLE:
        begin
          settle_delay <= 8'h00;
          state <= TBD_SETTLE;
        end
        TBD_SETTLE:
          if (SCAN_TICK_O)
          begin
            if (settle_delay + 8'h01 >= settle_target) // [RULE1]
              state <= TBD_WAIT;
            settle_delay <= settle_delay + 8'h01;
          end
        TBD_WAIT:
          if (SAMPLE_VALID_I)
          begin
            cur_sensor <= (cur_sensor == SW'(NUM_SENSORS - 1)) ? '0 : cur_sensor + SW'(1);
            state <= TBD_IDLE;
          end
      endcase
    end
  end

  assign CONV_START_O = (state == TBD_WAIT);
  assign CONV_SENSOR_O = cur_sensor[$clog2(NUM_SENSORS)-1:0];

  //============================================================================
  // Per-sensor detection and baseline, one sensor updated per sample
  logic [CW-1:0] baseline [NUM_SENSORS];
  logic [7:0] bucket [NUM_SENSORS];
  logic [7:0] debounce_count [NUM_SENSORS];
  logic [7:0] low_cnt [NUM_SENSORS];
  logic [NUM_SENSORS-1:0] active;

  logic signed [CW:0] diff;
  logic [CW-1:0] cur_base;
  logic [7:0] ft;
  logic [7:0] nt;
  logic [8:0] on_level;
  logic signed [9:0] off_level;
  logic above_on;
  logic below_off;
  logic pos_small;
  logic neg_big;

  assign cur_base = baseline[cur_sensor];
  assign ft = FINGER_TH_I[cur_sensor*8 +: 8];
  assign nt = NOISE_TH_I[cur_sensor*8 +: 8];
  assign diff = $signed({1'b0, RAW_COUNT_I}) - $signed({1'b0, cur_base}); // [RULE16]
  assign on_level = {1'b0, ft} + {1'b0, detect_hysteresis}; // [RULE13]
  assign off_level = $signed({2'b00, ft}) - $signed({2'b00, detect_hysteresis});
  assign above_on = diff > $signed({{(CW-8){1'b0}}, on_level}); // [RULE7]
  assign below_off = diff < $signed({{(CW-9){off_level[9]}}, off_level}); // [RULE8]
  assign pos_small = (diff >= 0) && (diff < $signed({{(CW-7){1'b0}}, nt})); // [RULE6]
  assign neg_big = -diff > $signed({{(CW-7){1'b0}}, negative_noise_threshold}); // [RULE11]

  always_ff @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      active <= '0;
      for (int i = 0; i < NUM_SENSORS; i++)
      begin
        baseline[i] <= '0;
        bucket[i] <= 8'h00;
        debounce_count[i] <= 8'h00;
        low_cnt[i] <= 8'h00;
      end
    end
    else if (state == TBD_WAIT && SAMPLE_VALID_I)
    begin
      // Detection with hysteresis and debounce
      if (!active[cur_sensor])
      begin
        if (above_on)
        begin
          if (debounce_count[cur_sensor] + 8'h01 >= activation_debounce) // [RULE10]
          begin
            active[cur_sensor] <= 1'b1;
            debounce_count[cur_sensor] <= 8'h00;
          end
          else
            debounce_count[cur_sensor] <= debounce_count[cur_sensor] + 8'h01;
        end
        else
          debounce_count[cur_sensor] <= 8'h00; // [RULE10]
      end
      else if (below_off)
        active[cur_sensor] <= 1'b0; // [RULE8]

      // Baseline tracking
      // Auto reset must still follow deep dips, so the low hold applies only with it off
      if (neg_big && !auto_baseline_reset)
      begin
        bucket[cur_sensor] <= 8'h00;
        if (low_cnt[cur_sensor] + 8'h01 >= low_baseline_reset_count) // [RULE12]
        begin
          baseline[cur_sensor] <= RAW_COUNT_I;
          low_cnt[cur_sensor] <= 8'h00;
        end
        else
          low_cnt[cur_sensor] <= low_cnt[cur_sensor] + 8'h01; // [RULE11]
      end
      else
      begin
        low_cnt[cur_sensor] <= 8'h00;
        if (auto_baseline_reset || diff < 0)
        begin
          // Auto reset tracks every sample; small dips follow directly
          baseline[cur_sensor] <= RAW_COUNT_I; // [RULE5]
          bucket[cur_sensor] <= 8'h00;
        end
        else if (pos_small) // [RULE14]
        begin
          if ({1'b0, bucket[cur_sensor]} + {1'b0, diff[7:0]} >= {1'b0, BL_UPDATE_TH_I}) // [RULE15]
          begin
            baseline[cur_sensor] <= cur_base + CW'(1);
            bucket[cur_sensor] <= 8'h00;
          end
          else
            bucket[cur_sensor] <= bucket[cur_sensor] + diff[7:0];
        end
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_SENSORS; i++)
      BASELINE_O[i*CW +: CW] = baseline[i];
  end

  assign SENSOR_ACTIVE_O = active;
endmodule
